//--- pkg/ocfs_pkg.sv
// Package with register map, selector codes and divider constants for the output clock selector.
package ocfs_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_SEL_1_2 = 12'h060;
  localparam logic [ADDR_W-1:0] IDX_SEL_3_4 = 12'h061;
  localparam logic [ADDR_W-1:0] IDX_SEL_5_6 = 12'h062;
  localparam logic [ADDR_W-1:0] IDX_AUX_CTRL = 12'h070;
  localparam logic [ADDR_W-1:0] IDX_STATUS   = 12'h071;

  localparam logic [7:0] RST_SEL_1_2 = 8'h85;
  localparam logic [7:0] RST_SEL_3_4 = 8'h86;
  localparam logic [7:0] RST_SEL_5_6 = 8'h8A;
  localparam logic [3:0] RST_AUX_FREQ = 4'h1;
  localparam logic       RST_AUX_SRC  = 1'b0;

  // Field positions in the auxiliary control register.
  localparam int unsigned AUX_FREQ_LSB = 0;
  localparam int unsigned AUX_SRC_BIT  = 4;

  localparam logic [3:0] AUX_FREQ_62M5 = 4'h9;
  localparam int unsigned AUX_APLL_MULT = 4;

  // Selector codes.
  localparam logic [3:0] SEL_OFF  = 4'h0;
  localparam logic [3:0] SEL_2K   = 4'h1;
  localparam logic [3:0] SEL_8K   = 4'h2;
  localparam logic [3:0] SEL_DIGB = 4'h3;
  localparam logic [3:0] SEL_DIGA = 4'h4;
  localparam logic [3:0] SEL_M48  = 4'h5;
  localparam logic [3:0] SEL_M16  = 4'h6;
  localparam logic [3:0] SEL_M12  = 4'h7;
  localparam logic [3:0] SEL_M8   = 4'h8;
  localparam logic [3:0] SEL_M6   = 4'h9;
  localparam logic [3:0] SEL_M4   = 4'hA;
  localparam logic [3:0] SEL_A64  = 4'hB;
  localparam logic [3:0] SEL_A48  = 4'hC;
  localparam logic [3:0] SEL_A16  = 4'hD;
  localparam logic [3:0] SEL_A8   = 4'hE;
  localparam logic [3:0] SEL_A4   = 4'hF;

  // Half periods, in APLL ticks, of each divide ratio.
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] HALF_48 = 5'h18;
  localparam logic [CNT_W-1:0] HALF_16 = 5'h08;
  localparam logic [CNT_W-1:0] HALF_12 = 5'h06;
  localparam logic [CNT_W-1:0] HALF_8  = 5'h04;
  localparam logic [CNT_W-1:0] HALF_6  = 5'h03;
  localparam logic [CNT_W-1:0] HALF_4  = 5'h02;
  localparam logic [CNT_W-1:0] HALF_2  = 5'h01;
  localparam logic [CNT_W-1:0] HALF_10 = 5'h05;
  // Divide by 64 has a half period of 32, stored as 0 in the 5-bit counter terminal.
  localparam logic [CNT_W-1:0] HALF_64 = 5'h00;

  // Fixed frequency timing on the 200 MHz system clock.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned F2K_HZ = 2_000;
  localparam int unsigned F8K_HZ = 8_000;
  localparam int unsigned HALF_2K_CYC = CLK_HZ / (2 * F2K_HZ);
  localparam int unsigned HALF_8K_CYC = CLK_HZ / (2 * F8K_HZ);

  typedef enum logic [2:0] {
    OCFS_SRC_OFF  = 3'h0,
    OCFS_SRC_2K   = 3'h1,
    OCFS_SRC_8K   = 3'h2,
    OCFS_SRC_DIGB = 3'h3,
    OCFS_SRC_DIGA = 3'h4,
    OCFS_SRC_MAIN = 3'h5,
    OCFS_SRC_AUX  = 3'h6
  } ocfs_src_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ocfs_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } ocfs_apb_rsp_t;

  typedef struct packed {
    logic main_tick;
    logic aux_tick;
    logic tick_2k;
    logic tick_8k;
    logic dig_a;
    logic dig_b;
    logic aux_div10;
  } ocfs_src_bus_t;

endpackage

//--- rtl/ocfs_channel.sv
// One output clock channel: selector decode, divider and output flip-flop.
`timescale 1ns/1ps
`default_nettype none
module ocfs_channel #(
  parameter bit IS_OUT4 = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [3:0]            sel,
  input  wire ocfs_pkg::ocfs_src_bus_t src,
  output logic                       clk_out_q
);

  logic [3:0]                   sel_q;
  logic [ocfs_pkg::CNT_W-1:0]   cnt_q;
  ocfs_pkg::ocfs_src_t          kind;
  logic [ocfs_pkg::CNT_W-1:0]   half;
  logic                         tick;
  logic                         changed;

  always_comb begin
    kind = ocfs_pkg::OCFS_SRC_MAIN;
    half = ocfs_pkg::HALF_4;
    unique case (sel)
      ocfs_pkg::SEL_OFF:  kind = ocfs_pkg::OCFS_SRC_OFF;
      ocfs_pkg::SEL_2K:   kind = ocfs_pkg::OCFS_SRC_2K;
      ocfs_pkg::SEL_8K:   kind = ocfs_pkg::OCFS_SRC_8K;
      ocfs_pkg::SEL_DIGB: kind = ocfs_pkg::OCFS_SRC_DIGB;
      ocfs_pkg::SEL_DIGA: kind = ocfs_pkg::OCFS_SRC_DIGA;
      ocfs_pkg::SEL_M48:  half = ocfs_pkg::HALF_48;
      ocfs_pkg::SEL_M16:  half = ocfs_pkg::HALF_16;
      ocfs_pkg::SEL_M12:  half = ocfs_pkg::HALF_12;
      ocfs_pkg::SEL_M8:   half = ocfs_pkg::HALF_8;
      ocfs_pkg::SEL_M6:   half = ocfs_pkg::HALF_6;
      ocfs_pkg::SEL_M4:   half = ocfs_pkg::HALF_4;
      ocfs_pkg::SEL_A64: begin
        kind = ocfs_pkg::OCFS_SRC_AUX;
        half = IS_OUT4 ? ocfs_pkg::HALF_2 : ocfs_pkg::HALF_64;
      end
      ocfs_pkg::SEL_A48: begin
        kind = ocfs_pkg::OCFS_SRC_AUX;
        half = src.aux_div10 ? ocfs_pkg::HALF_10 : ocfs_pkg::HALF_48;
      end
      ocfs_pkg::SEL_A16: begin
        kind = ocfs_pkg::OCFS_SRC_AUX;
        half = ocfs_pkg::HALF_16;
      end
      ocfs_pkg::SEL_A8: begin
        kind = ocfs_pkg::OCFS_SRC_AUX;
        half = ocfs_pkg::HALF_8;
      end
      ocfs_pkg::SEL_A4: begin
        kind = ocfs_pkg::OCFS_SRC_AUX;
        half = ocfs_pkg::HALF_4;
      end
    endcase
  end

  assign tick = (kind == ocfs_pkg::OCFS_SRC_MAIN) ? src.main_tick : src.aux_tick;
  assign changed = (sel != sel_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= 4'h0;
    end else begin
      sel_q <= sel;
    end
  end

  // A selector change restarts only this channel's divider from low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q     <= '0;
      clk_out_q <= 1'b0;
    end else if (changed) begin
      cnt_q     <= '0;
      clk_out_q <= 1'b0;
    end else begin
      unique case (kind)
        ocfs_pkg::OCFS_SRC_OFF:  clk_out_q <= 1'b0;
        ocfs_pkg::OCFS_SRC_2K:   if (src.tick_2k) clk_out_q <= ~clk_out_q;
        ocfs_pkg::OCFS_SRC_8K:   if (src.tick_8k) clk_out_q <= ~clk_out_q;
        ocfs_pkg::OCFS_SRC_DIGB: clk_out_q <= src.dig_b;
        ocfs_pkg::OCFS_SRC_DIGA: clk_out_q <= src.dig_a;
        default: begin
          if (tick) begin
            // Synchronous divider counting selected APLL ticks.
            if (cnt_q + 5'h01 == half) begin
              cnt_q     <= '0;
              clk_out_q <= ~clk_out_q;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- rtl/ocfs_top.sv
// APB register file and six output clock channels for the output frequency selector.
//
// Functional notes
// - Selector nibbles: odd-even pairs per register, odd output in the low nibble, even in the high.
// - Code 0000 holds the output low.
// - Codes 0011/0100 route digital frequency B/A.
// - Codes 0101-1010 divide main APLL 48..4.
// - Code 1011 divides auxiliary APLL by 64.
// - Output four code 1011 divides by 2.
// - Codes 1100-1111 divide auxiliary APLL 48,16,8,4.
// - 62.5MHz auxiliary DPLL, local lock: divide 10.
// - Source bit set locks auxiliary APLL to main.
// - Auxiliary APLL runs four times its DPLL.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ocfs_top #(
  parameter int unsigned HALF_2K = ocfs_pkg::HALF_2K_CYC,
  parameter int unsigned HALF_8K = ocfs_pkg::HALF_8K_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire ocfs_pkg::ocfs_apb_req_t apb_req,
  output ocfs_pkg::ocfs_apb_rsp_t      apb_rsp,
  input  wire logic                    main_apll_tick,
  input  wire logic                    aux_apll_tick,
  input  wire logic                    prog_digital_freq_a,
  input  wire logic                    prog_digital_freq_b,
  output logic [3:0]                   aux_dpll_freq_sel,
  output logic                         aux_apll_source_sel,
  output logic                         clock_out_one,
  output logic                         clock_out_two,
  output logic                         clock_out_three,
  output logic                         clock_out_four,
  output logic                         clock_out_five,
  output logic                         clock_out_six
);

  if (HALF_2K < 1 || HALF_8K < 1 || HALF_8K > HALF_2K) begin : g_bad_param
    $error("ocfs_top: fixed clock half periods must be nonzero and 8k not above 2k");
  end

  localparam int unsigned FIX_W = $clog2(HALF_2K + 1);
  localparam int unsigned NCH   = 6;

  logic [7:0]              sel_1_2_q;
  logic [7:0]              sel_3_4_q;
  logic [7:0]              sel_5_6_q;
  logic [3:0]              aux_freq_q;
  logic                    aux_src_q;
  logic [FIX_W-1:0]        cnt_2k_q;
  logic [FIX_W-1:0]        cnt_8k_q;
  logic                    tick_2k_q;
  logic                    tick_8k_q;
  logic [NCH-1:0]          ch_out;
  logic [NCH*4-1:0]        sel_all;
  ocfs_pkg::ocfs_src_bus_t src;
  logic                    setup;
  logic                    wr_en;
  logic [ocfs_pkg::ADDR_W-1:0] idx;
  logic                    idx_ok;
  logic [ocfs_pkg::DATA_W-1:0] rd_val;

  // APB decode: only word-aligned addresses map; index is address over four.
  assign idx   = {2'b00, apb_req.paddr[ocfs_pkg::ADDR_W-1:2]};
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
                 && !apb_rsp.pslverr;

  always_comb begin
    idx_ok = (apb_req.paddr[1:0] == 2'b00);
    rd_val = '0;
    unique case (idx)
      ocfs_pkg::IDX_SEL_1_2:  rd_val[7:0] = sel_1_2_q;
      ocfs_pkg::IDX_SEL_3_4:  rd_val[7:0] = sel_3_4_q;
      ocfs_pkg::IDX_SEL_5_6:  rd_val[7:0] = sel_5_6_q;
      ocfs_pkg::IDX_AUX_CTRL: begin
        rd_val[ocfs_pkg::AUX_FREQ_LSB +: 4] = aux_freq_q;
        rd_val[ocfs_pkg::AUX_SRC_BIT]       = aux_src_q;
      end
      ocfs_pkg::IDX_STATUS:   rd_val[NCH-1:0] = ch_out;
      default:                idx_ok = 1'b0;
    endcase
  end

  // Zero-wait slave: answer registered in the setup cycle, shown in the access cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      apb_rsp <= '0;
    end else if (setup) begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.pslverr <= !idx_ok;
      apb_rsp.prdata  <= apb_req.pwrite ? '0 : rd_val;
    end else begin
      apb_rsp <= '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_1_2_q <= ocfs_pkg::RST_SEL_1_2;
      sel_3_4_q <= ocfs_pkg::RST_SEL_3_4;
      sel_5_6_q <= ocfs_pkg::RST_SEL_5_6;
    end else if (wr_en) begin
      if (idx == ocfs_pkg::IDX_SEL_1_2) sel_1_2_q <= apb_req.pwdata[7:0];
      if (idx == ocfs_pkg::IDX_SEL_3_4) sel_3_4_q <= apb_req.pwdata[7:0];
      if (idx == ocfs_pkg::IDX_SEL_5_6) sel_5_6_q <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_freq_q <= ocfs_pkg::RST_AUX_FREQ;
      aux_src_q  <= ocfs_pkg::RST_AUX_SRC;
    end else if (wr_en && idx == ocfs_pkg::IDX_AUX_CTRL) begin
      aux_freq_q <= apb_req.pwdata[ocfs_pkg::AUX_FREQ_LSB +: 4];
      aux_src_q  <= apb_req.pwdata[ocfs_pkg::AUX_SRC_BIT];
    end
  end

  // The PLL settings go out to the auxiliary PLL pair; it multiplies by four.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_dpll_freq_sel   <= ocfs_pkg::RST_AUX_FREQ;
      aux_apll_source_sel <= ocfs_pkg::RST_AUX_SRC;
    end else begin
      aux_dpll_freq_sel   <= aux_freq_q;
      aux_apll_source_sel <= aux_src_q;
    end
  end

  // Fixed 2kHz and 8kHz come from dividing the system clock into toggle pulses.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_2k_q  <= '0;
      tick_2k_q <= 1'b0;
    end else if (cnt_2k_q == FIX_W'(HALF_2K - 1)) begin
      cnt_2k_q  <= '0;
      tick_2k_q <= 1'b1;
    end else begin
      cnt_2k_q  <= cnt_2k_q + FIX_W'(1);
      tick_2k_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_8k_q  <= '0;
      tick_8k_q <= 1'b0;
    end else if (cnt_8k_q == FIX_W'(HALF_8K - 1)) begin
      cnt_8k_q  <= '0;
      tick_8k_q <= 1'b1;
    end else begin
      cnt_8k_q  <= cnt_8k_q + FIX_W'(1);
      tick_8k_q <= 1'b0;
    end
  end

  // Divide by ten applies only with 62.5MHz auxiliary DPLL and local APLL lock,
  // giving 250MHz over ten, that is 25MHz.
  always_comb begin
    src.main_tick = main_apll_tick;
    src.aux_tick  = aux_apll_tick;
    src.tick_2k   = tick_2k_q;
    src.tick_8k   = tick_8k_q;
    src.dig_a     = prog_digital_freq_a;
    src.dig_b     = prog_digital_freq_b;
    src.aux_div10 = (aux_freq_q == ocfs_pkg::AUX_FREQ_62M5) && !aux_src_q;
  end

  assign sel_all = {sel_5_6_q, sel_3_4_q, sel_1_2_q};

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    ocfs_channel #(
      .IS_OUT4 (i == 3)
    ) u_ch (
      .clk       (clk),
      .rstn      (rstn),
      .sel       (sel_all[i*4 +: 4]),
      .src       (src),
      .clk_out_q (ch_out[i])
    );
  end

  assign clock_out_one   = ch_out[0];
  assign clock_out_two   = ch_out[1];
  assign clock_out_three = ch_out[2];
  assign clock_out_four  = ch_out[3];
  assign clock_out_five  = ch_out[4];
  assign clock_out_six   = ch_out[5];

endmodule
`default_nettype wire

//--- bench/ocfs_top_monitor.sv
// Checker for the register bus and output one of the output clock selector.
`timescale 1ns/1ps
`default_nettype none
module ocfs_top_monitor (
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire ocfs_pkg::ocfs_apb_req_t apb_req,
  input wire ocfs_pkg::ocfs_apb_rsp_t apb_rsp,
  input wire logic                    main_apll_tick,
  input wire logic [3:0]              aux_dpll_freq_sel,
  input wire logic                    aux_apll_source_sel,
  input wire logic                    clock_out_one,
  input wire logic                    clock_out_two,
  input wire logic                    clock_out_three,
  input wire logic                    clock_out_four,
  input wire logic                    clock_out_five,
  input wire logic                    clock_out_six
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic       acc;
  logic [3:0] sel1_q;
  logic [4:0] aux_q;
  logic [5:0] outs;
  assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign outs = {clock_out_six, clock_out_five, clock_out_four,
                 clock_out_three, clock_out_two, clock_out_one};
  // Shadow copies of what software wrote, so outputs can be tied to their cause.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel1_q <= ocfs_pkg::RST_SEL_1_2[3:0];
      aux_q  <= {ocfs_pkg::RST_AUX_SRC, ocfs_pkg::RST_AUX_FREQ};
    end else if (acc && apb_req.pwrite && apb_req.paddr == 12'h180) begin
      sel1_q <= apb_req.pwdata[3:0];
    end else if (acc && apb_req.pwrite && apb_req.paddr == 12'h1C0) begin
      aux_q <= apb_req.pwdata[4:0];
    end
  end
  chk_ready_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside an access phase");
  chk_setup_answer: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("access phase not answered at once");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  chk_misalign_err: assert property (acc && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr)
    else $error("misaligned access not refused");
  chk_write_rdata: assert property (acc && apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
    else $error("write returned read data");
  chk_aux_copy: assert property ($stable(aux_q) |-> {aux_apll_source_sel, aux_dpll_freq_sel} == aux_q)
    else $error("auxiliary control outputs differ from register");
  chk_off_low: assert property (sel1_q == 4'h0 |=> !clock_out_one)
    else $error("disabled output not low");
  chk_main_hold: assert property ($stable(sel1_q) && sel1_q >= 4'h5 && sel1_q <= 4'hA &&
    !main_apll_tick && !$past(main_apll_tick) |=> $stable(clock_out_one))
    else $error("main divided output moved without a tick");
  chk_status_read: assert property (acc && !apb_req.pwrite && apb_req.paddr == 12'h1C4 &&
    $stable(outs) |-> apb_rsp.prdata[5:0] == outs)
    else $error("status read differs from outputs");
endmodule
bind ocfs_top ocfs_top_monitor ocfs_top_monitor_i (.clk, .rstn, .apb_req, .apb_rsp,
  .main_apll_tick, .aux_dpll_freq_sel, .aux_apll_source_sel, .clock_out_one, .clock_out_two,
  .clock_out_three, .clock_out_four, .clock_out_five, .clock_out_six);
`default_nettype wire

//--- bench/ocfs_top_tb.sv
// Self-checking testbench for the output clock frequency selector.
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, b, m) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module ocfs_top_tb;
  localparam logic [11:0] A12 = ocfs_pkg::IDX_SEL_1_2 << 2;
  localparam logic [11:0] A34 = ocfs_pkg::IDX_SEL_3_4 << 2;
  localparam logic [11:0] A56 = ocfs_pkg::IDX_SEL_5_6 << 2;
  localparam logic [11:0] AUX = ocfs_pkg::IDX_AUX_CTRL << 2;
  localparam logic [11:0] STS = ocfs_pkg::IDX_STATUS << 2;
  localparam int          H2K = 8;
  localparam int          H8K = 2;
  localparam int          RT [16] = '{0, 2*H2K, 2*H8K, 0, 0, 48, 16, 12, 8, 6, 4,
                                      64, 48, 16, 8, 4};
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  logic                    slow = 1'b0;
  logic                    dig_a = 1'b0;
  logic                    dig_b = 1'b0;
  logic [1:0]              tc = 2'h0;
  logic                    tk;
  logic [3:0]              afs;
  logic                    asrc;
  logic [5:0]              outs;
  logic [31:0]             rdv;
  logic                    errv;
  ocfs_pkg::ocfs_apb_req_t req = '0;
  ocfs_pkg::ocfs_apb_rsp_t rsp;
  int                      mismatches = 0;
  int                      compares = 0;
  ocfs_top #(.HALF_2K(H2K), .HALF_8K(H8K)) ocfs_top_i (.clk(clk), .rstn(rstn), .apb_req(req),
    .apb_rsp(rsp), .main_apll_tick(tk), .aux_apll_tick(tk), .prog_digital_freq_a(dig_a),
    .prog_digital_freq_b(dig_b), .aux_dpll_freq_sel(afs), .aux_apll_source_sel(asrc),
    .clock_out_one(outs[0]), .clock_out_two(outs[1]), .clock_out_three(outs[2]),
    .clock_out_four(outs[3]), .clock_out_five(outs[4]), .clock_out_six(outs[5]));
  initial forever #2.5 clk = ~clk;
  // In slow mode the APLL ticks come every third cycle, so dividers must hold between them.
  always @(posedge clk) tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
  assign tk = !slow || tc == 2'h0;
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd_o, output logic err_o);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    rd_o = rsp.prdata;
    err_o = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, errv);
    `CMP(errv, 1'b0, "write refused")
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h0, rdv, errv);
    `CMP(rdv, exp, "read data")
    `CMP(errv, eexp, "error response")
  endtask
  // Counts cycles from one rising edge of an output to the next.
  task automatic period(input int ch, input int exp);
    int n;
    n = 0;
    while (outs[ch] !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    while (outs[ch] !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (outs[ch] !== 1'b0 && n < 400);
    while (outs[ch] !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CMP(n, exp, "output period")
    if (n >= 400) end_sim();
  endtask
  task automatic s_regs();
    rd(A12, 32'h00000085, 1'b0);
    rd(A34, 32'h00000086, 1'b0);
    rd(A56, 32'h0000008A, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
    apb(1'b1, A12 + 12'h2, 32'h0000003C, rdv, errv);
    `CMP(errv, 1'b1, "misaligned write accepted")
    rd(A12, 32'h00000085, 1'b0);
    wr(A12, 32'hFFFFFF3C);
    rd(A12, 32'h0000003C, 1'b0);
  endtask
  task automatic s_ratios();
    for (int c = 1; c < 16; c++) begin
      if (c != 3 && c != 4) begin
        slow <= (c >= 5 && c <= 10);
        wr(A12, {28'h0, c[3:0]});
        period(0, (c >= 5 && c <= 10) ? 3 * RT[c] : RT[c]);
      end
    end
  endtask
  task automatic s_aux();
    wr(AUX, 32'h00000009);
    wr(A12, 32'h0000000C);
    `CMP(afs, ocfs_pkg::AUX_FREQ_62M5, "auxiliary frequency setting")
    period(0, 10);
    wr(AUX, 32'h00000019);
    period(0, 48);
    `CMP({asrc, afs}, 5'h19, "auxiliary control outputs")
  endtask
  task automatic s_pairs();
    wr(A12, 32'h000000A0);
    period(1, 4);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      `CMP(outs[0], 1'b0, "disabled output toggled")
    end
    wr(A34, 32'h000000B0);
    period(3, 2);
    wr(A34, 32'h0000000B);
    period(2, 64);
    wr(A56, 32'h000000F0);
    period(5, 4);
    wr(A56, 32'h0000000D);
    period(4, 16);
    wr(A56, 32'h0);
  endtask
  task automatic s_indep();
    logic p;
    int   st;
    st = 0;
    wr(A34, 32'h000000B0);
    repeat (2) @(posedge clk);
    fork
      wr(A34, 32'h000000B7);
      repeat (8) begin
        p = outs[3];
        @(posedge clk);
        st += (outs[3] === p);
      end
    join
    `CMP(st, 0, "untouched output disturbed")
  endtask
  task automatic s_dig();
    wr(A34, 32'h0);
    wr(A12, 32'h00000043);
    dig_a <= 1'b1;
    repeat (3) @(posedge clk);
    `CMP(outs[1:0], 2'h2, "digital routing")
    rd(STS, 32'h00000002, 1'b0);
    dig_a <= 1'b0;
    dig_b <= 1'b1;
    repeat (3) @(posedge clk);
    `CMP(outs[1:0], 2'h1, "digital routing")
  endtask
  // A reset in mid-run must bring every output low and the output five/six selector and auxiliary control registers back to reset values.
  task automatic s_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    `CMP(outs, 6'h00, "outputs not low in reset")
    `CMP({asrc, afs}, {ocfs_pkg::RST_AUX_SRC, ocfs_pkg::RST_AUX_FREQ}, "aux reset")
    rstn <= 1'b1;
    @(posedge clk);
    rd(A56, 32'h0000008A, 1'b0);
    rd(AUX, 32'h00000001, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    s_regs();
    s_ratios();
    s_aux();
    s_pairs();
    s_indep();
    s_dig();
    s_reset();
    end_sim();
  end
endmodule
`default_nettype wire
